// ==== core/user_counter_consts.svh ====
`ifndef USER_COUNTER_CONSTS_SVH
`define USER_COUNTER_CONSTS_SVH
// Register word indices (byte address is four times the index)
`define IDX_DATA0 6'h18
`define IDX_DATA1 6'h1a
`define IDX_DATA2 6'h1c
`define IDX_CTRL  6'h1e
`define IDX_GCC0  6'h20
`define IDX_GCC1  6'h22
`define IDX_GCC2  6'h24
`define IDX_ICS   6'h26
// Control word fields
`define CW_SEL_LSB  6
`define CW_RW_LSB   4
`define CW_MODE_LSB 1
// Gate and clock control fields
`define GCC_CSRC_LSB  0
`define GCC_SWCLK_BIT 3
`define GCC_GSRC_LSB  4
`define GCC_GPOL_BIT  6
`define GCC_SWG_BIT   7
`define GCC_GSTAT_BIT 8
`define GCC_CSTAT_BIT 10
// Reset values
`define GCC_RST 8'h00
`define ICS_RST 2'h0
// Rates in kHz
`define SYS_CLK_KHZ  100000
`define ICLK_10M_KHZ 10000
`define ICLK_1M_KHZ  1000
`define ICLK_100K_KHZ 100
`define ICLK_10K_KHZ 10
`endif

// ==== core/uc_pkg.sv ====
package uc_pkg;
  typedef enum logic [1:0] {
    MODE_TERM    = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_SQUARE  = 2'b11
  } cnt_mode_t;
  typedef enum logic [1:0] {
    RW_LATCH = 2'b00,
    RW_LSB   = 2'b01,
    RW_MSB   = 2'b10,
    RW_WORD  = 2'b11
  } rw_mode_t;
endpackage

// ==== core/user_counter_group.sv ====
// Functional notes
// - Mode 3 divides clock by loaded count
// - Single counter reaches 5 MHz output
// - Mode 1 one pulse, count clocks wide
// - One-shot pulse is always active low
// - Low-gate counter counts only while gate low, except mode 1
// - Counter one output gates counter two
// - Clock select 0x03 gives 10 kHz
// - Control 0x72 sets counter one mode 1
// - Control 0xb0 sets counter two mode 0
// - Data writes low byte then high byte
// - Gate clock control 0x00 restores defaults
// - 0x80 raises gate, 0x88 gives clock
// - 0x52 gates counter two from counter one
// - 0x81 selects internal clock source
// - Status shows gate bit 8, clock bit 10
// - Data reads return low then high byte
// - Gate polarity decides when counter runs
// - Previous counter order is 2, 0, 1
// - Clock select 0x00 gives 10 MHz
`timescale 1ns/10ps
`default_nettype none
`include "user_counter_consts.svh"
module user_counter_group
  import uc_pkg::*;
#(
  parameter int unsigned HALF_10M  = `SYS_CLK_KHZ / (2 * `ICLK_10M_KHZ),
  parameter int unsigned HALF_1M   = `SYS_CLK_KHZ / (2 * `ICLK_1M_KHZ),
  parameter int unsigned HALF_100K = `SYS_CLK_KHZ / (2 * `ICLK_100K_KHZ),
  parameter int unsigned HALF_10K  = `SYS_CLK_KHZ / (2 * `ICLK_10K_KHZ)
) (
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [2:0]  EXT_CLK,
  input  wire logic [2:0]  EXT_GATE,
  output logic      [2:0]  COUNTER_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic [1:0]  ics_reg;
  logic [12:0] div_reg;
  logic [12:0] half_sel;
  logic        int_clk_reg;
  logic [2:0]  eclk_s1_reg, eclk_s2_reg;
  logic [2:0]  egate_s1_reg, egate_s2_reg;
  wire  logic  req    = AVS_READ | AVS_WRITE;
  wire  logic  acc    = req & ~wait_reg;
  wire  logic  wr_acc = AVS_WRITE & acc & AVS_BYTEENABLE[0];
  wire  logic  rd_acc = AVS_READ & acc;
  wire  logic  ics_wr = wr_acc & (AVS_ADDRESS == `IDX_ICS);
  wire  logic [7:0] wd = AVS_WRITEDATA[7:0];
  wire  logic [2:0] out_w;
  wire  logic [2:0] clk_lvl_w;
  wire  logic [2:0] gate_lvl_w;
  wire  logic [2:0][7:0] gcc_w;
  wire  logic [2:0][7:0] rd_byte_w;

  // One wait cycle per access; result stands at the edge waitrequest is low
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~(req & wait_reg);
    end
  end

  // Read mux, unmapped and write-only words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (AVS_ADDRESS == `IDX_DATA0) begin
      rd_mux = {24'h00_0000, rd_byte_w[0]};
    end else if (AVS_ADDRESS == `IDX_DATA1) begin
      rd_mux = {24'h00_0000, rd_byte_w[1]};
    end else if (AVS_ADDRESS == `IDX_DATA2) begin
      rd_mux = {24'h00_0000, rd_byte_w[2]};
    end else if (AVS_ADDRESS == `IDX_GCC0) begin
      rd_mux = {21'h0, clk_lvl_w[0], 1'b0, gate_lvl_w[0], gcc_w[0]};
    end else if (AVS_ADDRESS == `IDX_GCC1) begin
      rd_mux = {21'h0, clk_lvl_w[1], 1'b0, gate_lvl_w[1], gcc_w[1]};
    end else if (AVS_ADDRESS == `IDX_GCC2) begin
      rd_mux = {21'h0, clk_lvl_w[2], 1'b0, gate_lvl_w[2], gcc_w[2]};
    end else if (AVS_ADDRESS == `IDX_ICS) begin
      rd_mux = {30'h0, ics_reg};
    end
  end

  // Read data sampled in the wait cycle, held until the next read
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ & wait_reg) begin
      rdata_reg <= rd_mux;
    end
  end
  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign COUNTER_OUT     = out_w;

  // Internal clock select register
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ics_reg <= `ICS_RST;
    end else if (ics_wr) begin
      ics_reg <= wd[1:0];
    end
  end

  // rate select; 10 MHz lets a count of 2 give 5 MHz
  always_comb begin
    case (ics_reg)
      2'h0:    half_sel = 13'(HALF_10M);
      2'h1:    half_sel = 13'(HALF_1M);
      2'h2:    half_sel = 13'(HALF_100K);
      default: half_sel = 13'(HALF_10K);
    endcase
  end

  // Divider restarts on a select write so the new rate begins cleanly
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg     <= 13'h0000;
      int_clk_reg <= 1'b0;
    end else if (ics_wr) begin
      div_reg <= 13'h0000;
    end else if (div_reg == half_sel - 13'h0001) begin
      div_reg     <= 13'h0000;
      int_clk_reg <= ~int_clk_reg;
    end else begin
      div_reg <= div_reg + 13'h0001;
    end
  end

  // Pin synchronisers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      eclk_s1_reg  <= 3'h0;
      eclk_s2_reg  <= 3'h0;
      egate_s1_reg <= 3'h0;
      egate_s2_reg <= 3'h0;
    end else begin
      eclk_s1_reg  <= EXT_CLK;
      eclk_s2_reg  <= eclk_s1_reg;
      egate_s1_reg <= EXT_GATE;
      egate_s2_reg <= egate_s1_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : gen_cnt
      localparam int PREV = (i + 2) % 3;
      localparam logic [5:0] DIDX = `IDX_DATA0 + 6'(2 * i);
      localparam logic [5:0] GIDX = `IDX_GCC0 + 6'(2 * i);
      logic [7:0]  gcc_reg;
      logic [15:0] cnt_reg, reload_reg, latch_reg, hold_reg;
      cnt_mode_t   mode_reg;
      rw_mode_t    rw_reg;
      logic        out_reg, wr_hi_reg, rd_hi_reg, latched_reg;
      logic        cnt_ok_reg, load_pend_reg, trig_reg;
      logic        clk_prev_reg, gate_prev_reg;
      logic        clk_lvl, gate_lvl, gate_act;
      logic [16:0] half;
      wire logic [15:0] val = latched_reg ? latch_reg : cnt_reg;
      wire logic cw_sel = wr_acc & (AVS_ADDRESS == `IDX_CTRL)
                          & (wd[`CW_SEL_LSB+:2] == 2'(i));
      wire logic cw_hit  = cw_sel & (wd[`CW_RW_LSB+:2] != RW_LATCH);
      wire logic lat_hit = cw_sel & (wd[`CW_RW_LSB+:2] == RW_LATCH);
      wire logic dw_hit  = wr_acc & (AVS_ADDRESS == DIDX);
      wire logic dr_hit  = rd_acc & (AVS_ADDRESS == DIDX);
      wire logic wr_done = dw_hit & ((rw_reg != RW_WORD) | wr_hi_reg);
      wire logic clk_ev  = clk_lvl & ~clk_prev_reg;
      wire logic g_rise  = gate_act & ~gate_prev_reg;

      // clock source; previous counter feeds the next one
      always_comb begin
        case (gcc_reg[`GCC_CSRC_LSB+:2])
          2'h0:    clk_lvl = gcc_reg[`GCC_SWCLK_BIT];
          2'h1:    clk_lvl = int_clk_reg;
          2'h2:    clk_lvl = eclk_s2_reg[i];
          default: clk_lvl = out_w[PREV];
        endcase
        case (gcc_reg[`GCC_GSRC_LSB+:2])
          2'h1:    gate_lvl = out_w[PREV];
          2'h2:    gate_lvl = egate_s2_reg[i];
          default: gate_lvl = gcc_reg[`GCC_SWG_BIT];
        endcase
        gate_act = gcc_reg[`GCC_GPOL_BIT] ? ~gate_lvl : gate_lvl;
        half = (reload_reg == 16'h0000) ? 17'h0_8000 : {2'b00, reload_reg[15:1]};
      end
      assign out_w[i]      = out_reg;
      assign clk_lvl_w[i]  = clk_lvl;
      assign gate_lvl_w[i] = gate_lvl;
      assign gcc_w[i]      = gcc_reg;
      // high byte comes from the copy taken at the low byte read
      assign rd_byte_w[i]  = (rw_reg == RW_MSB) ? val[15:8] :
                             (rw_reg == RW_WORD && rd_hi_reg) ? hold_reg[7:0] : val[7:0];

      // gate and clock control, 0x00 is the idle setting
      always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          gcc_reg       <= `GCC_RST;
          clk_prev_reg  <= 1'b0;
          gate_prev_reg <= 1'b0;
        end else begin
          if (wr_acc & (AVS_ADDRESS == GIDX)) begin
            gcc_reg <= wd;
          end
          clk_prev_reg  <= clk_lvl;
          gate_prev_reg <= gate_act;
        end
      end

      // Counting core; control word beats data write beats clock edge
      always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          mode_reg      <= MODE_TERM;
          rw_reg        <= RW_WORD;
          cnt_reg       <= 16'h0000;
          reload_reg    <= 16'h0000;
          wr_hi_reg     <= 1'b0;
          cnt_ok_reg    <= 1'b0;
          load_pend_reg <= 1'b0;
          trig_reg      <= 1'b0;
          out_reg       <= 1'b1;
        end else begin
          if (cw_hit) begin
            // mode and byte order; bit 3 of mode is a don't care
            case (wd[`CW_MODE_LSB+:2])
              2'b01:   mode_reg <= MODE_ONESHOT;
              2'b11:   mode_reg <= MODE_SQUARE;
              default: mode_reg <= MODE_TERM;
            endcase
            rw_reg        <= rw_mode_t'(wd[`CW_RW_LSB+:2]);
            out_reg       <= (wd[`CW_MODE_LSB+:2] == 2'b01) | (wd[`CW_MODE_LSB+:2] == 2'b11);
            wr_hi_reg     <= 1'b0;
            cnt_ok_reg    <= 1'b0;
            load_pend_reg <= 1'b0;
            trig_reg      <= 1'b0;
          end else if (dw_hit) begin
            // low byte first in word order
            if (rw_reg == RW_MSB || (rw_reg == RW_WORD && wr_hi_reg)) begin
              reload_reg[15:8] <= wd;
            end else begin
              reload_reg[7:0] <= wd;
            end
            wr_hi_reg <= (rw_reg == RW_WORD) & ~wr_hi_reg;
            if (wr_done) begin
              cnt_ok_reg    <= 1'b1;
              load_pend_reg <= 1'b1;
              if (mode_reg == MODE_TERM) begin
                out_reg <= 1'b0;
              end
            end
          end else if (clk_ev & cnt_ok_reg) begin
            case (mode_reg)
              MODE_ONESHOT: begin
                // low from the trigger edge for count clocks
                if (trig_reg) begin
                  cnt_reg  <= reload_reg;
                  out_reg  <= 1'b0;
                  trig_reg <= 1'b0;
                end else if (!out_reg) begin
                  cnt_reg <= cnt_reg - 16'h0001;
                  out_reg <= (cnt_reg == 16'h0001);
                end
              end
              MODE_SQUARE: begin
                // reload every count clocks, high for the upper half
                if (!gate_act) begin
                  out_reg       <= 1'b1;
                  load_pend_reg <= 1'b1;
                end else if (load_pend_reg || cnt_reg == 16'h0001) begin
                  cnt_reg       <= reload_reg;
                  out_reg       <= 1'b1;
                  load_pend_reg <= 1'b0;
                end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
                  out_reg <= ({1'b0, cnt_reg} - 17'h0_0001) > half;
                end
              end
              default: begin
                // first edge loads, then counts only while enabled
                if (load_pend_reg) begin
                  cnt_reg       <= reload_reg;
                  load_pend_reg <= 1'b0;
                end else if (gate_act) begin
                  cnt_reg <= cnt_reg - 16'h0001;
                  if (cnt_reg == 16'h0001) begin
                    out_reg <= 1'b1;
                  end
                end
              end
            endcase
          end
          // trigger is kept even when it meets a firing edge
          if (g_rise & (mode_reg == MODE_ONESHOT) & ~cw_hit) begin
            trig_reg <= 1'b1;
          end
        end
      end

      // read side: latch command and byte pairing of reads
      always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          latched_reg <= 1'b0;
          latch_reg   <= 16'h0000;
          hold_reg    <= 16'h0000;
          rd_hi_reg   <= 1'b0;
        end else if (cw_hit) begin
          latched_reg <= 1'b0;
          rd_hi_reg   <= 1'b0;
        end else if (lat_hit & ~latched_reg) begin
          latched_reg <= 1'b1;
          latch_reg   <= cnt_reg;
        end else if (dr_hit) begin
          if (rw_reg == RW_WORD && !rd_hi_reg) begin
            rd_hi_reg <= 1'b1;
            hold_reg  <= {8'h00, val[15:8]};
          end else begin
            rd_hi_reg   <= 1'b0;
            latched_reg <= 1'b0;
          end
        end
      end

      sequence s_swclk_up;
        wr_acc && AVS_ADDRESS == GIDX && wd[`GCC_SWCLK_BIT] && wd[1:0] == 2'h0
          && !gcc_reg[`GCC_SWCLK_BIT] && gcc_reg[1:0] == 2'h0;
      endsequence
      property p_swclk_pulse;
        s_swclk_up |=> clk_ev ##1 !clk_ev;
      endproperty
      a_swclk_pulse: assert property (p_swclk_pulse) else $error("soft clock gave no single edge");

      property p_os_neg;
        mode_reg == MODE_ONESHOT && $past(mode_reg) == MODE_ONESHOT && $fell(out_reg)
          |-> $past(trig_reg && clk_ev && cnt_ok_reg);
      endproperty
      a_os_neg: assert property (p_os_neg) else $error("one-shot fell without trigger");

      property p_os_end;
        mode_reg == MODE_ONESHOT && !out_reg && clk_ev && !trig_reg && cnt_reg == 16'h0001
          && !cw_hit && !dw_hit |=> out_reg && cnt_reg == 16'h0000;
      endproperty
      a_os_end: assert property (p_os_end) else $error("one-shot width wrong");

      property p_sq_reload;
        mode_reg == MODE_SQUARE && clk_ev && gate_act && cnt_ok_reg && cnt_reg == 16'h0001
          && !cw_hit && !dw_hit |=> out_reg && cnt_reg == $past(reload_reg);
      endproperty
      a_sq_reload: assert property (p_sq_reload) else $error("rate period reload missed");

      property p_gate_hold;
        mode_reg == MODE_TERM && clk_ev && !gate_act && !load_pend_reg && !cw_hit && !dw_hit
          |=> $stable(cnt_reg);
      endproperty
      a_gate_hold: assert property (p_gate_hold) else $error("counted with gate disabled");

      property p_word_load;
        dw_hit && !cw_hit && rw_reg == RW_WORD && wr_hi_reg
          |=> reload_reg[15:8] == $past(wd) && load_pend_reg && cnt_ok_reg && !wr_hi_reg;
      endproperty
      a_word_load: assert property (p_word_load) else $error("high byte not paired");
    end
  endgenerate

  // Helper for the rate checks: cycles between internal clock changes
  logic [13:0] gap_reg;
  logic        gap_ok_reg, int_prev_reg;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_reg      <= 14'h0000;
      gap_ok_reg   <= 1'b0;
      int_prev_reg <= 1'b0;
    end else begin
      int_prev_reg <= int_clk_reg;
      if (ics_wr) begin
        gap_ok_reg <= 1'b0;
        gap_reg    <= 14'h0001;
      end else if (int_clk_reg != int_prev_reg) begin
        gap_ok_reg <= 1'b1;
        gap_reg    <= 14'h0001;
      end else begin
        gap_reg <= gap_reg + 14'h0001;
      end
    end
  end

  property p_ics_10k;
    int_clk_reg != int_prev_reg && gap_ok_reg && !ics_wr && ics_reg == 2'h3
      |-> gap_reg == 14'(HALF_10K);
  endproperty
  a_ics_10k: assert property (p_ics_10k) else $error("10 kHz half period wrong");

  property p_ics_10m;
    int_clk_reg != int_prev_reg && gap_ok_reg && !ics_wr && ics_reg == 2'h0
      |-> gap_reg == 14'(HALF_10M);
  endproperty
  a_ics_10m: assert property (p_ics_10m) else $error("10 MHz half period wrong");

  sequence s_new_req;
    req && wait_reg;
  endsequence
  property p_bus_answer;
    s_new_req |=> !wait_reg ##1 wait_reg;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

  property p_gcc_read;
    rd_acc && AVS_ADDRESS == `IDX_GCC2
      |=> AVS_READDATA[`GCC_GSTAT_BIT] == $past(gate_lvl_w[2], 2)
        && AVS_READDATA[`GCC_CSTAT_BIT] == $past(clk_lvl_w[2], 2);
  endproperty
  a_gcc_read: assert property (p_gcc_read) else $error("status levels wrong");
endmodule
`default_nettype wire

// ==== tb/ext_wiring_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ext_wiring_model #(
  parameter int unsigned HALF = 3
) (
  input  wire logic       clk,
  input  wire logic       run,
  output logic      [2:0] ext_clk,
  output logic      [2:0] ext_gate
);
  int unsigned cnt = 0;
  logic        meas = 1'b0;
  // Measured signal for counter two; held low outside a measurement so no stray events land
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      meas <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      meas <= ~meas;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Unused pins rest at their pull-down level
  assign ext_clk  = {meas, 2'b00};
  assign ext_gate = 3'b000;
endmodule
`default_nettype wire

// ==== tb/user_counter_rate_oneshot_freq_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "user_counter_consts.svh"
module user_counter_rate_oneshot_freq_tb;
  typedef struct {logic [7:0] ics; logic [7:0] n; int hi; int lo;} rate_t;
  typedef struct {logic [5:0] a; logic [7:0] d; logic [31:0] m; logic [31:0] e;} reg_t;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        run = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] q;
  logic [15:0] v;
  logic [15:0] v2;
  wire logic [31:0] rdata;
  wire logic        wait_req;
  wire logic [2:0]  ext_clk;
  wire logic [2:0]  ext_gate;
  wire logic [2:0]  cnt_out;
  int          bad_count = 0;
  int          comparisons = 0;
  int          h;
  int          l;
  int          m;
  // Event spacing: 10 MHz is 10 cycles, 1 MHz 100, 10 kHz 40 with the shortened divider
  rate_t rates[4] = '{'{8'h00, 8'h02, 10, 10}, '{8'h00, 8'h05, 30, 20},
                      '{8'h01, 8'h02, 100, 100}, '{8'h03, 8'h02, 40, 40}};
  reg_t regs[8] = '{'{`IDX_ICS, 8'h03, 32'hff, 32'h03}, '{`IDX_ICS, 8'h00, 32'hff, 32'h00},
                    '{`IDX_GCC1, 8'h81, 32'hff, 32'h81}, '{`IDX_GCC1, 8'h00, 32'hff, 32'h00},
                    '{`IDX_GCC2, 8'h52, 32'hff, 32'h52}, '{`IDX_GCC2, 8'h00, 32'hff, 32'h00},
                    '{`IDX_CTRL, 8'h30, 32'hffffffff, 32'h0}, '{6'h3f, 8'h5a, 32'hffffffff, 32'h0}};

  initial forever #5 clk = ~clk;

  user_counter_group #(.HALF_10K(20)) i_dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .EXT_CLK(ext_clk), .EXT_GATE(ext_gate), .COUNTER_OUT(cnt_out)
  );

  ext_wiring_model #(.HALF(3)) i_wiring (.clk(clk), .run(run), .ext_clk(ext_clk), .ext_gate(ext_gate));

  task automatic summarize;
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic c, input string s);
    comparisons++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask

  // One access; request held until waitrequest is seen low, data taken at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    k = 0;
    // No local limit: a missing answer is left to the watchdog
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0);
    // Exactly one wait cycle is promised for every access
    chk(k == 2, "bus answer not after one wait cycle");
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrt(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask

  // Byte pair read: low byte first, then high byte
  task automatic rd16(input logic [5:0] a, output logic [15:0] r);
    bus(1'b0, a, 8'h00, q);
    r[7:0] = q[7:0];
    bus(1'b0, a, 8'h00, q);
    r[15:8] = q[7:0];
  endtask

  // Cycles spent at one level of an output, once that level is reached
  task automatic span(input int i, input logic lv, output int w);
    int k;
    k = 0;
    while (cnt_out[i] !== lv && k < 3000) begin
      @(posedge clk);
      k++;
    end
    w = 0;
    while (cnt_out[i] === lv && w < 3000) begin
      @(posedge clk);
      w++;
    end
  endtask

  task automatic stays_high(input int cycles, output int errs);
    errs = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (cnt_out[1] !== 1'b1) errs++;
    end
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    #(20000 * 10);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    summarize;
  end

  initial begin
    repeat (2) @(posedge clk);
    chk(wait_req === 1'b1 && cnt_out === 3'b111, "reset outputs");
    arst_n <= 1'b1;
    foreach (regs[i]) begin
      wrt(regs[i].a, regs[i].d);
      bus(1'b0, regs[i].a, 8'h00, q);
      chk((q & regs[i].m) === regs[i].e, "register readback");
    end
    // Rate generation: high gate type, load divisor, then raise the gate
    foreach (rates[i]) begin
      wrt(`IDX_ICS, rates[i].ics);
      wrt(`IDX_CTRL, 8'h76);
      wrt(`IDX_DATA1, rates[i].n);
      wrt(`IDX_DATA1, 8'h00);
      wrt(`IDX_GCC1, 8'h81);
      span(1, 1'b0, h);
      span(1, 1'b1, h);
      span(1, 1'b0, l);
      chk(h == rates[i].hi && l == rates[i].lo, "rate period");
    end
    wrt(`IDX_ICS, 8'h00);
    wrt(`IDX_GCC1, 8'h01);
    repeat (30) @(posedge clk);
    stays_high(50, m);
    chk(m == 0, "gate low still toggles");
    // One-shot by software clock; count must read back as 10000
    wrt(`IDX_CTRL, 8'h72);
    wrt(`IDX_DATA1, 8'h10);
    wrt(`IDX_DATA1, 8'h27);
    wrt(`IDX_GCC1, 8'h00);
    wrt(`IDX_GCC1, 8'h80);
    wrt(`IDX_GCC1, 8'h88);
    wrt(`IDX_GCC1, 8'h80);
    chk(cnt_out[1] === 1'b0, "one-shot not low");
    rd16(`IDX_DATA1, v);
    chk(v === 16'h2710, "count byte order");
    // One-shot on internal clock, count 3 gives 30 cycles low, once
    wrt(`IDX_CTRL, 8'h72);
    wrt(`IDX_DATA1, 8'h03);
    wrt(`IDX_DATA1, 8'h00);
    wrt(`IDX_GCC1, 8'h01);
    wrt(`IDX_GCC1, 8'h81);
    span(1, 1'b0, l);
    chk(l == 30, "one-shot width");
    stays_high(100, m);
    chk(m == 0, "second pulse");
    // Status bits follow soft gate and soft clock
    wrt(`IDX_GCC2, 8'h88);
    bus(1'b0, `IDX_GCC2, 8'h00, q);
    chk((q & 32'h500) === 32'h500, "status high");
    wrt(`IDX_GCC2, 8'h00);
    bus(1'b0, `IDX_GCC2, 8'h00, q);
    chk((q & 32'h500) === 32'h000, "status low");
    // Frequency measurement: counter one window gates counter two
    wrt(`IDX_CTRL, 8'h72);
    wrt(`IDX_DATA1, 8'h03);
    wrt(`IDX_DATA1, 8'h00);
    wrt(`IDX_GCC1, 8'h01);
    wrt(`IDX_CTRL, 8'hb0);
    wrt(`IDX_DATA2, 8'hff);
    wrt(`IDX_DATA2, 8'hff);
    wrt(`IDX_GCC2, 8'h80);
    wrt(`IDX_GCC2, 8'h88);
    wrt(`IDX_GCC2, 8'h00);
    wrt(`IDX_GCC2, 8'h52);
    run <= 1'b1;
    repeat (50) @(posedge clk);
    rd16(`IDX_DATA2, v);
    chk(v === 16'hffff, "counted with gate high");
    bus(1'b0, `IDX_GCC2, 8'h00, q);
    chk(q[8] === 1'b1, "gate level");
    wrt(`IDX_GCC1, 8'h81);
    repeat (100) @(posedge clk);
    rd16(`IDX_DATA2, v);
    chk(16'hffff - v >= 16'd4 && 16'hffff - v <= 16'd6, "event count");
    repeat (40) @(posedge clk);
    rd16(`IDX_DATA2, v2);
    chk(v2 === v, "count after window");
    run <= 1'b0;
    chk(cnt_out[2] === 1'b0, "mode 0 output rose before terminal count");
    // Reset in mid-run puts outputs and settings back to idle
    arst_n <= 1'b0;
    @(posedge clk);
    chk(wait_req === 1'b1 && cnt_out === 3'b111 && rdata === 32'h0, "mid-run reset outputs");
    arst_n <= 1'b1;
    bus(1'b0, `IDX_GCC2, 8'h00, q);
    chk(q[7:0] === 8'h00, "gate clock control after reset");
    summarize;
  end
endmodule
`default_nettype wire
